// *** ifd_pkg.sv ***
// package: instruction decode constants, enums and carrier structs
package ifd_pkg;
    // program word width
    localparam int unsigned WORD_W = 16;
    // oscillator periods per instruction cycle
    localparam int unsigned Q_PER_CYCLE = 4;
    localparam logic [1:0] Q_LAST = 2'h3;
    // counts of the instruction set
    localparam int unsigned BASE_COUNT = 75;
    localparam int unsigned EXT_COUNT = 8;
    // second word of a double-word instruction: top nibble all ones
    localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
    // bit-test-and-skip opcodes
    localparam logic [3:0] OP_SKIP_CLR = 4'hB;
    localparam logic [3:0] OP_SKIP_SET = 4'hA;
    // double-word first-word patterns (upper byte, masked)
    localparam logic [7:0] DW_MOVE_PAIR = 8'hC0;   // top nibble 1100
    localparam logic [7:0] DW_GOTO = 8'hEF;
    localparam logic [7:0] DW_CALL_LO = 8'hEC;     // ec/ed
    localparam logic [7:0] DW_LOAD_PTR = 8'hEE;
    // extended group prefix 1110_1000 .. 1110_1011
    localparam logic [5:0] EXT_PREFIX = 6'h3A;     // 1110_10xx
    // field positions
    localparam int unsigned F_LSB = 0;
    localparam int unsigned D_BIT = 9;
    localparam int unsigned A_BIT = 8;
    localparam int unsigned B_LSB = 9;
    localparam int unsigned S_BIT = 0;
    // destination encodings
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // operation class
    typedef enum logic [2:0] {
        IFD_CLS_BYTE,
        IFD_CLS_BIT,
        IFD_CLS_LIT,
        IFD_CLS_CTRL,
        IFD_CLS_NOP
    } ifd_class_t;

    // decoded operand fields
    typedef struct packed {
        ifd_class_t cls;
        logic [7:0] file_addr;
        logic dest_file;
        logic access_sel;
        logic [2:0] bit_num;
        logic [7:0] literal;
        logic [1:0] ptr_sel;
        logic [10:0] prog_addr;
        logic shadow_mode;
        logic [1:0] table_mode;
        logic two_word;
        logic skip_clr;
        logic skip_set;
        logic branch;
        logic extended;
    } ifd_fields_t;
endpackage

// *** ifd_qgen.sv ***
// quarter-cycle phase generator: one instruction cycle per four clocks
`timescale 1ns/1ps
module ifd_qgen (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // phase outputs
    output logic [1:0] o_phase,
    output logic o_cycle_end
);
    import ifd_pkg::*;

    logic [1:0] phase_q; // current quarter

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign o_phase = phase_q;
    // pulse on the last quarter of each instruction cycle
    assign o_cycle_end = (phase_q == Q_LAST);
endmodule // ifd_qgen

// *** ifd_fields.sv ***
// combinational operand field decoder for one program word
`timescale 1ns/1ps
module ifd_fields (
    // word in
    input wire logic [15:0] i_word,
    // decoded fields
    output ifd_pkg::ifd_fields_t o_fields
);
    import ifd_pkg::*;

    wire logic [3:0] top_nib = i_word[15:12];
    wire logic [7:0] top_byte = i_word[15:8];
    // double-word first words
    wire logic is_movff = (top_nib == DW_MOVE_PAIR[7:4]);
    wire logic is_goto = (top_byte == DW_GOTO);
    wire logic is_call = (top_byte[7:1] == DW_CALL_LO[7:1]);
    wire logic is_lfsr = (top_byte == DW_LOAD_PTR) && (i_word[7:6] == 2'h0);
    // lone second word
    wire logic is_second = (top_nib == SECOND_WORD_TAG);
    wire logic is_ext = (i_word[15:10] == EXT_PREFIX);
    wire logic is_skip_clr = (top_nib == OP_SKIP_CLR);
    wire logic is_skip_set = (top_nib == OP_SKIP_SET);
    wire logic is_bitop = (top_nib[3:2] == 2'h2) || (top_nib == 4'h7);
    wire logic is_branch = (top_nib == 4'hD) || (top_nib == 4'hE && !is_ext
        && !is_call && !is_lfsr && top_byte != DW_GOTO);
    wire logic is_lit = (top_nib == 4'h0 && i_word[11:8] != 4'h0) || is_lfsr || is_ext;

    always_comb begin
        o_fields = '0;
        o_fields.file_addr = i_word[7:0];
        o_fields.access_sel = i_word[A_BIT];
        o_fields.dest_file = i_word[D_BIT];
        o_fields.bit_num = i_word[11:9];
        o_fields.literal = i_word[7:0];
        o_fields.ptr_sel = i_word[5:4];
        o_fields.prog_addr = i_word[10:0];
        o_fields.shadow_mode = i_word[S_BIT];
        o_fields.table_mode = i_word[1:0];
        o_fields.two_word = is_movff || is_goto || is_call || is_lfsr;
        o_fields.skip_clr = is_skip_clr;
        o_fields.skip_set = is_skip_set;
        o_fields.branch = is_branch || is_goto || is_call;
        o_fields.extended = is_ext;
        if (is_second && !is_ext) begin
            o_fields.cls = IFD_CLS_NOP;
            o_fields.two_word = 1'b0;
            o_fields.branch = 1'b0;
        end else if (is_skip_clr || is_skip_set || is_bitop) begin
            o_fields.cls = IFD_CLS_BIT;
        end else if (is_lit) begin
            o_fields.cls = IFD_CLS_LIT;
        end else if (o_fields.branch || top_nib == 4'h0) begin
            o_fields.cls = IFD_CLS_CTRL;
        end else begin
            o_fields.cls = IFD_CLS_BYTE;
        end
    end
endmodule // ifd_fields

// *** ifd_core.sv ***
// instruction format and timing sequencer: fetch, decode, skip, cycle count
`timescale 1ns/1ps
module ifd_core (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // program memory side
    input wire logic [15:0] i_prog_word,
    input wire logic i_prog_valid,
    output logic o_fetch,
    // configuration and condition inputs
    input wire logic i_ext_enable,
    input wire logic i_branch_taken,
    input wire logic [7:0] i_file_data,
    // decoded result to the data path
    output ifd_pkg::ifd_fields_t o_fields,
    output logic o_exec,
    output logic o_write_acc,
    output logic o_write_file,
    output logic o_nop_cycle,
    output logic o_status_we,
    output logic [1:0] o_phase,
    output logic [1:0] o_cycles_used
);
    import ifd_pkg::*;

    typedef enum logic [1:0] {
        IFD_ST_FIRST,
        IFD_ST_SECOND,
        IFD_ST_FLUSH
    } ifd_state_t;

    ifd_state_t state_q; // sequencer state
    ifd_state_t state_d;
    ifd_fields_t fld_q; // held decode of the current instruction
    ifd_fields_t fld_w; // decode of the incoming word
    logic [1:0] flush_q; // nop cycles still owed
    logic [1:0] flush_d;
    logic [1:0] used_q; // cycles the last instruction took
    logic [1:0] used_d;
    logic [1:0] run_q; // cycles of the current instruction so far
    logic [1:0] run_d;
    logic exec_q; // execute pulse of a real instruction
    logic cycle_end; // last quarter of instruction cycle
    logic [1:0] phase;

    // quarter phase generator
    ifd_qgen u_qgen (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .o_phase(phase),
        .o_cycle_end(cycle_end)
    );

    // field decoder of the fetched word
    ifd_fields u_fields (
        .i_word(i_prog_word),
        .o_fields(fld_w)
    );

    // selected bit of the file operand
    wire logic sel_bit = i_file_data[fld_q.bit_num];
    wire logic skip_hit = (fld_q.skip_clr && !sel_bit) || (fld_q.skip_set && sel_bit);
    // extended words are nops while the extension is off
    wire logic ext_block = fld_w.extended && !i_ext_enable;
    wire logic word_ok = i_prog_valid && !ext_block;
    // taken branch in a single word costs one extra cycle
    wire logic taken = fld_q.branch && i_branch_taken;

    // sequencer next state
    always_comb begin
        state_d = state_q;
        flush_d = flush_q;
        used_d = used_q;
        run_d = run_q;
        if (cycle_end) begin
            case (state_q)
                IFD_ST_FIRST: begin
                    run_d = 2'h1;
                    if (word_ok && fld_w.two_word) begin
                        state_d = IFD_ST_SECOND;
                    end else begin
                        used_d = 2'h1;
                    end
                end
                IFD_ST_SECOND: begin
                    run_d = run_q + 2'h1;
                    if (taken) begin
                        state_d = IFD_ST_FLUSH;
                        // execute cycle, then one nop for the discarded fetch
                        flush_d = 2'h2;
                    end else begin
                        state_d = IFD_ST_FIRST;
                        used_d = run_q + 2'h1;
                    end
                end
                IFD_ST_FLUSH: begin
                    run_d = run_q + 2'h1;
                    flush_d = flush_q - 2'h1;
                    if (flush_q == 2'h1) begin
                        state_d = IFD_ST_FIRST;
                        // run already counts this last flush cycle
                        used_d = run_q;
                    end
                end
                default: begin
                    state_d = IFD_ST_FIRST;
                end
            endcase
            if (state_q == IFD_ST_FIRST && exec_q && !fld_q.two_word
                && (skip_hit || taken)) begin
                state_d = IFD_ST_FLUSH;
                // skip over a double word costs two nops
                flush_d = (skip_hit && word_ok && fld_w.two_word) ? 2'h2 : 2'h1;
                run_d = 2'h2;
            end
        end
    end

    // state registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= IFD_ST_FIRST;
            flush_q <= 2'h0;
            used_q <= 2'h0;
            run_q <= 2'h0;
        end else begin
            state_q <= state_d;
            flush_q <= flush_d;
            used_q <= used_d;
            run_q <= run_d;
        end
    end

    // capture decode of each new first word
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fld_q <= '0;
            exec_q <= 1'b0;
        end else if (cycle_end) begin
            // one word per fetch
            // the word fetched as a flush ends is the next real instruction
            if (state_d == IFD_ST_FIRST
                && (state_q == IFD_ST_FIRST || state_q == IFD_ST_FLUSH)) begin
                fld_q <= fld_w;
                exec_q <= word_ok && fld_w.cls != IFD_CLS_NOP;
            end else if (state_q == IFD_ST_FIRST && state_d == IFD_ST_SECOND) begin
                fld_q <= fld_w;
                exec_q <= 1'b0;
            end else if (state_q == IFD_ST_SECOND) begin
                exec_q <= 1'b1;
            end else begin
                exec_q <= 1'b0;
            end
        end
    end

    // fetch at each cycle boundary
    assign o_fetch = cycle_end;
    assign o_fields = fld_q;
    assign o_exec = exec_q;
    assign o_phase = phase;
    assign o_cycles_used = used_q;
    assign o_nop_cycle = !exec_q || state_q == IFD_ST_FLUSH;
    assign o_write_acc = exec_q && fld_q.cls == IFD_CLS_BYTE && fld_q.dest_file == DEST_ACC;
    assign o_write_file = exec_q && fld_q.cls == IFD_CLS_BYTE && fld_q.dest_file == DEST_FILE;
    assign o_status_we = exec_q && fld_q.cls == IFD_CLS_BYTE
        && !fld_q.skip_clr && !fld_q.skip_set;
endmodule // ifd_core

// *** ifd_core_properties.sv ***
// checker: timing and decode properties of the instruction sequencer
`timescale 1ns/1ps
module ifd_core_properties
    import ifd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // watched ports
    input wire logic [15:0] i_prog_word,
    input wire logic i_prog_valid,
    input wire logic o_fetch,
    input wire logic [7:0] i_file_data,
    input wire ifd_pkg::ifd_fields_t o_fields,
    input wire logic o_exec,
    input wire logic o_write_acc,
    input wire logic o_write_file,
    input wire logic o_nop_cycle,
    input wire logic o_status_we,
    input wire logic [1:0] o_phase
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // last word taken, for field comparisons
    logic [15:0] word_q;
    // capture on each fetch edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            word_q <= 16'h0000;
        end else if (o_fetch) begin
            word_q <= i_prog_word;
        end
    end
    a_phase_walk: assert property (o_phase == 2'h0 |=> o_phase == 2'h1 ##1 o_phase == 2'h2
        ##1 o_phase == 2'h3 ##1 o_phase == 2'h0) else $error("phase does not step by one");
    a_fetch_last: assert property (o_fetch == (o_phase == Q_LAST))
        else $error("fetch not on last quarter");
    a_fields_hold: assert property (o_phase != Q_LAST |=> $stable(o_fields))
        else $error("decode changed inside a cycle");
    a_skip_fields: assert property (o_fetch && i_prog_valid && i_prog_word[15:12] == OP_SKIP_CLR
        |=> !o_exec || (o_fields.skip_clr && o_fields.bit_num == word_q[11:9]
        && o_fields.file_addr == word_q[7:0])) else $error("skip fields wrong");
    a_lone_second: assert property (o_fetch && i_prog_valid && i_prog_word[15:12] == SECOND_WORD_TAG
        && !o_fields.two_word |=> o_nop_cycle && !o_write_acc && !o_write_file)
        else $error("lone second word not a nop");
    a_dest_acc: assert property (o_write_acc |-> o_fields.cls == IFD_CLS_BYTE
        && o_fields.dest_file == DEST_ACC) else $error("accumulator write without d=0");
    a_dest_file: assert property (o_write_file |-> o_fields.cls == IFD_CLS_BYTE
        && o_fields.dest_file == DEST_FILE) else $error("file write without d=1");
    a_skip_quiet: assert property (o_fields.skip_clr || o_fields.skip_set |-> !o_status_we)
        else $error("skip touched status");
    a_skip_flush: assert property (o_fetch && o_exec && o_fields.skip_clr
        && !i_file_data[o_fields.bit_num] |=> o_nop_cycle [*4]) else $error("skip not flushed");
endmodule // ifd_core_properties

bind ifd_core ifd_core_properties i_props (.i_clk, .i_rst, .i_prog_word, .i_prog_valid,
    .o_fetch, .i_file_data, .o_fields, .o_exec, .o_write_acc, .o_write_file, .o_nop_cycle,
    .o_status_we, .o_phase);

// *** ifd_prog_mem.sv ***
// program memory model: hands out one word per fetch from a preloaded image
`timescale 1ns/1ps
module ifd_prog_mem (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // fetch side
    input wire logic i_fetch,
    input wire logic [15:0] i_image [16],
    output logic [15:0] o_word,
    output logic o_valid
);
    // word pointer, advanced by each taken fetch
    logic [3:0] pc_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_q <= 4'h0;
        end else if (i_fetch) begin
            pc_q <= pc_q + 4'h1;
        end
    end
    // inverted word in reset so a stale value never looks valid
    assign o_word = i_rst ? ~i_image[pc_q] : i_image[pc_q];
    assign o_valid = ~i_rst;
endmodule // ifd_prog_mem

// *** testbench.sv ***
// testbench: runs a short program through the sequencer, checking the cycles that its table marks for a check
`timescale 1ns/1ps
module testbench;
    import ifd_pkg::*;
    // clock, reset and counters
    logic i_clk;
    logic i_rst;
    int bad_count = 0;
    int check_count = 0;
    // design wires
    logic [15:0] image [16];
    logic [15:0] prog_word;
    logic prog_valid, fetch, exec, wacc, wfile, nop, status_we;
    logic [1:0] phase, cycles;
    ifd_fields_t fields;
    // word, flag check, {exec,nop,acc,file}, cycle check, cycles
    logic [23:0] prog [13] = '{{16'h2405, 1'h1, 4'hA, 1'h0, 2'h0}, {16'h2605, 1'h1, 4'h9, 1'h0, 2'h0},
        {16'hB610, 1'h1, 4'h8, 1'h0, 2'h0}, {16'h2605, 1'h1, 4'h4, 1'h0, 2'h0},
        {16'hA610, 1'h1, 4'h8, 1'h1, 2'h2}, {16'hF123, 1'h1, 4'h4, 1'h1, 2'h1},
        {16'hE823, 1'h1, 4'h4, 1'h0, 2'h0}, {16'hC010, 1'h1, 4'h4, 1'h0, 2'h0},
        {16'hF020, 1'h0, 4'h0, 1'h0, 2'h0}, {16'hEF10, 1'h1, 4'h4, 1'h1, 2'h2},
        {16'hF000, 1'h0, 4'h0, 1'h0, 2'h0}, {16'h0000, 1'h1, 4'h4, 1'h0, 2'h0},
        {16'h0000, 1'h0, 4'h0, 1'h1, 2'h3}};

    // far side and design, extended group off, file bit 3 clear
    ifd_prog_mem i_mem (.i_clk, .i_rst, .i_fetch(fetch), .i_image(image),
        .o_word(prog_word), .o_valid(prog_valid));
    ifd_core i_dut (.i_clk, .i_rst, .i_prog_word(prog_word), .i_prog_valid(prog_valid),
        .o_fetch(fetch), .i_ext_enable(1'h0), .i_branch_taken(1'h1), .i_file_data(8'hF7),
        .o_fields(fields), .o_exec(exec), .o_write_acc(wacc), .o_write_file(wfile),
        .o_nop_cycle(nop), .o_status_we(status_we), .o_phase(phase), .o_cycles_used(cycles));

    // compare and count
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // clock generator
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    // watchdog for a hung sequencer
    initial begin
        #(400 * 10);
        bad_count++;
        test_done;
    end

    // main sequence
    initial begin
        int n;
        i_rst = 1'h1;
        for (int k = 0; k < 16; k++) image[k] = (k < 13) ? prog[k][23:8] : 16'h0000;
        repeat (10) @(negedge i_clk);
        check("phase", 16'h0000, {14'h0, phase});
        check("reset flags", 16'h0004, {12'h0, exec, nop, wacc, wfile});
        $display("test reset done");
        i_rst = 1'h0;
        for (int k = 0; k < 13; k++) begin
            n = 0;
            while (fetch !== 1'h1 && n < 8) begin
                @(negedge i_clk);
                n++;
            end
            if (n == 8) begin
                bad_count++;
            end
            @(negedge i_clk);
            if (prog[k][7]) check("flags", {12'h0, prog[k][6:3]}, {12'h0, exec, nop, wacc, wfile});
            if (prog[k][2]) check("cycles", {14'h0, prog[k][1:0]}, {14'h0, cycles});
            if (k == 2 || k == 4) check("skip fields", (k == 2) ? 16'h1310 : 16'h0B10,
                {3'h0, fields.skip_clr, fields.skip_set, fields.bit_num, fields.file_addr});
        end
        $display("test program done");
        test_done;
    end
endmodule // testbench
